// *** logic/ebs_pkg.sv ***
// Shared constants, register map and types of the external bus strobe sequencer
package ebs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ZONES  = 3;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] OFF_ZONE0  = 8'h00;
    localparam logic [7:0] OFF_ZONE1  = 8'h04;
    localparam logic [7:0] OFF_ZONE2  = 8'h08;
    localparam logic [7:0] OFF_CLKCTL = 8'h0c;
    localparam logic [7:0] OFF_WDATA  = 8'h10;
    localparam logic [7:0] OFF_REQ    = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_RDATA  = 8'h1c;

    localparam int unsigned CLK_TIMING_HALF_BIT = 0;
    localparam int unsigned CLK_BUS_HALF_BIT    = 1;
    localparam int unsigned REQ_ZONE_LSB        = 19;
    localparam int unsigned REQ_WRITE_BIT       = 21;
    localparam int unsigned STAT_BUSY_BIT       = 0;
    localparam int unsigned STAT_PEND_BIT       = 1;
    localparam int unsigned STAT_WAIT_LSB       = 8;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic       ready_async_select;
        logic       ready_sample_enable;
        logic       timing_double;
        logic [1:0] write_trail_count;
        logic [2:0] write_active_count;
        logic [1:0] write_lead_count;
        logic [1:0] read_trail_count;
        logic [2:0] read_active_count;
        logic [1:0] read_lead_count;
    } ebs_zone_timing_t;

    localparam int unsigned ZONE_CFG_W = $bits(ebs_zone_timing_t);

    // Slowest legal timing out of reset: all counts at maximum, ready ignored
    localparam ebs_zone_timing_t ZONE_CFG_RESET = '{
        ready_async_select: 1'b0, ready_sample_enable: 1'b0, timing_double: 1'b1,
        write_trail_count: 2'h3, write_active_count: 3'h7, write_lead_count: 2'h3,
        read_trail_count: 2'h3, read_active_count: 3'h7, read_lead_count: 2'h3};

    localparam logic [1:0] CLKCTL_RESET = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ALIGN  = 3'h1,
        ST_LEAD   = 3'h3,
        ST_ACTIVE = 3'h2,
        ST_TRAIL  = 3'h6
    } ebs_state_t;

endpackage : ebs_pkg

// *** logic/ebs_timing_clock_gen.sv ***
// Timing clock tick, output bus clock and its phase derived from mclk
`timescale 1ns/10ps
`default_nettype none
module ebs_timing_clock_gen (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic timing_half,
    input  wire logic bus_half,
    output logic      tim_tick,
    output logic      bus_rise,
    output logic      bus_phase,
    output logic      bus_clock_out
);
    import ebs_pkg::*;

    logic       div;
    logic       next_div;
    logic       next_bus_phase;
    logic [1:0] bcnt;
    logic [1:0] next_bcnt;
    logic       next_bclk;
    logic [1:0] half_per;

    ////////////////////////////////////////////////////////////////////////////
    // Timing clock is mclk or mclk/2; bus clock is timing clock or half of it
    always_comb begin
        next_div       = timing_half ? ~div : 1'b0;
        tim_tick       = timing_half ? div : 1'b1;
        bus_rise       = tim_tick & (~bus_half | ~bus_phase);
        next_bus_phase = bus_half ? (bus_phase ^ tim_tick) : 1'b0;
        next_bcnt      = bus_rise ? 2'h0 : 2'(bcnt + 2'h1);
        half_per       = 2'(timing_half) + 2'(bus_half);
        // At full mclk rate the pin cannot toggle per cycle; it stays high
        next_bclk      = (half_per == 2'h0) | (next_bcnt < half_per);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div           <= 1'b0;
            bus_phase     <= 1'b0;
            bcnt          <= 2'h0;
            bus_clock_out <= 1'b0;
        end else begin
            div           <= next_div;
            bus_phase     <= next_bus_phase;
            bcnt          <= next_bcnt;
            bus_clock_out <= next_bclk;
        end
    end

endmodule : ebs_timing_clock_gen
`default_nettype wire

// *** logic/ebs_external_bus_interface.sv ***
// External bus strobe sequencer with APB register file
//
// Operation
// - Illegal timing settings run as programmed
// - Timing clock full/half; bus clock full/half
// - Phases counted and strobes moved on ticks
// - Full rate: strobes change on bus rising
// - Half rate: edge follows cycle count parity
// - Access start aligns to bus rising edge
// - Strobe assert parity follows lead count
// - Strobe release parity follows lead plus active
// - Select release parity follows whole access
// - Insert alignment cycle before misaligned access
// - Alignment cycle keeps controls inactive
// - Address holds last value while inactive
// - Ready ignored when sampling disabled
// - Doubling scales counts; active adds one
// - Ready async when enable and mode set
// - Ready low adds one wait cycle
// - Independent timing set per zone
`timescale 1ns/10ps
`default_nettype none
module ebs_external_bus_interface (
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    output logic                             bus_clock_out,
    output logic      [ebs_pkg::ADDR_W-1:0]  external_address_bus,
    output logic      [ebs_pkg::ZONES-1:0]   zone_select_n,
    output logic                             read_strobe_n,
    output logic                             write_strobe_n,
    output logic                             direction_signal,
    input  wire logic [ebs_pkg::DATA_W-1:0]  data_in,
    output logic      [ebs_pkg::DATA_W-1:0]  data_out,
    output logic                             data_oe,
    input  wire logic                        external_ready_in
);
    import ebs_pkg::*;

    ebs_zone_timing_t   cfg [ZONES];
    ebs_zone_timing_t   next_cfg [ZONES];
    logic               timing_half, bus_half, next_timing_half, next_bus_half;
    logic [DATA_W-1:0]  wdata, next_wdata, rdata, next_rdata;
    logic [ADDR_W-1:0]  req_addr, next_req_addr;
    logic [1:0]         req_zone, next_req_zone;
    logic               req_write, next_req_write, pending, next_pending;
    logic [31:0]        next_prdata;
    logic               next_pready, next_pslverr, wr_acc, mapped;
    logic               tim_tick, bus_rise, bus_phase;
    logic               rdy_s1, rdy_s2, rdy_s3, ready_sample;
    logic [DATA_W-1:0]  din_s1, din_s2;
    ebs_state_t         state, next_state;
    logic [4:0]         cnt, next_cnt, acc_act, next_acc_act, acc_trail, next_acc_trail;
    logic [4:0]         st_lead, st_act, st_trail;
    logic               acc_write, next_acc_write, acc_rdy_en, next_acc_rdy_en;
    logic [7:0]         waits, next_waits, cyc, next_cyc;
    logic               do_start, busy;
    ebs_zone_timing_t   st_cfg;
    logic [ZONES-1:0]   next_zone_n;
    logic               next_rd_n, next_wr_n, next_dir, next_oe;
    logic [ADDR_W-1:0]  next_addr;

    function automatic logic [4:0] scaled(input logic [2:0] c, input logic dbl);
        return dbl ? {1'b0, c, 1'b0} : {2'b00, c};
    endfunction : scaled

    ////////////////////////////////////////////////////////////////////////////
    ebs_timing_clock_gen u_clk (
        .mclk          (mclk),
        .rstn          (rstn),
        .timing_half   (timing_half),
        .bus_half      (bus_half),
        .tim_tick      (tim_tick),
        .bus_rise      (bus_rise),
        .bus_phase     (bus_phase),
        .bus_clock_out (bus_clock_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs pass two flops; async ready gets one more stage of settling
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
            rdy_s3 <= 1'b0;
            din_s1 <= '0;
            din_s2 <= '0;
        end else begin
            rdy_s1 <= external_ready_in;
            rdy_s2 <= rdy_s1;
            rdy_s3 <= rdy_s2;
            din_s1 <= data_in;
            din_s2 <= din_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access phase, error on unmapped address
    assign busy   = pending | (state != ST_IDLE);
    assign wr_acc = psel & penable & pready & pwrite;

    generate
        for (genvar z = 0; z < ZONES; z++) begin : g_zone
            always_comb begin
                next_cfg[z] = cfg[z];
                if (wr_acc && paddr == 8'(z * 4)) begin
                    next_cfg[z] = ebs_zone_timing_t'(pwdata[ZONE_CFG_W-1:0]);
                end
            end
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    cfg[z] <= ZONE_CFG_RESET;
                end else begin
                    cfg[z] <= next_cfg[z];
                end
            end
        end
    endgenerate

    always_comb begin
        mapped = (paddr[1:0] == 2'h0) && (paddr <= OFF_RDATA);
        next_pready  = psel & ~penable;
        next_pslverr = psel & ~penable & ~mapped;
        next_prdata  = prdata;
        if (psel && !penable) begin
            case (paddr)
                OFF_ZONE0:  next_prdata = 32'(cfg[0]);
                OFF_ZONE1:  next_prdata = 32'(cfg[1]);
                OFF_ZONE2:  next_prdata = 32'(cfg[2]);
                OFF_CLKCTL: next_prdata = {30'h0, bus_half, timing_half};
                OFF_WDATA:  next_prdata = 32'(wdata);
                OFF_REQ:    next_prdata = {10'h0, req_write, req_zone, req_addr};
                OFF_STATUS: next_prdata = {16'h0, waits, 6'h0, pending, busy};
                OFF_RDATA:  next_prdata = 32'(rdata);
                default:    next_prdata = 32'h0;
            endcase
        end
        next_timing_half = timing_half;
        next_bus_half    = bus_half;
        next_wdata       = wdata;
        next_req_addr    = req_addr;
        next_req_zone    = req_zone;
        next_req_write   = req_write;
        next_pending     = pending & ~do_start;
        if (wr_acc && paddr == OFF_CLKCTL) begin
            next_timing_half = pwdata[CLK_TIMING_HALF_BIT];
            next_bus_half    = pwdata[CLK_BUS_HALF_BIT];
        end
        if (wr_acc && paddr == OFF_WDATA) begin
            next_wdata = pwdata[DATA_W-1:0];
        end
        // A request while busy or to a missing zone is dropped
        if (wr_acc && paddr == OFF_REQ && !busy && pwdata[REQ_ZONE_LSB +: 2] < 2'(ZONES)) begin
            next_req_addr  = pwdata[ADDR_W-1:0];
            next_req_zone  = pwdata[REQ_ZONE_LSB +: 2];
            next_req_write = pwdata[REQ_WRITE_BIT];
            next_pending   = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prdata      <= 32'h0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            timing_half <= CLKCTL_RESET[CLK_TIMING_HALF_BIT];
            bus_half    <= CLKCTL_RESET[CLK_BUS_HALF_BIT];
            wdata       <= '0;
            req_addr    <= '0;
            req_zone    <= 2'h0;
            req_write   <= 1'b0;
            pending     <= 1'b0;
        end else begin
            prdata      <= next_prdata;
            pready      <= next_pready;
            pslverr     <= next_pslverr;
            timing_half <= next_timing_half;
            bus_half    <= next_bus_half;
            wdata       <= next_wdata;
            req_addr    <= next_req_addr;
            req_zone    <= next_req_zone;
            req_write   <= next_req_write;
            pending     <= next_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer; settings are executed as given, legal or not
    always_comb begin
        st_cfg   = cfg[req_zone];
        st_lead  = scaled({1'b0, req_write ? st_cfg.write_lead_count : st_cfg.read_lead_count},
                          st_cfg.timing_double);
        st_act   = scaled(req_write ? st_cfg.write_active_count : st_cfg.read_active_count,
                          st_cfg.timing_double);
        st_trail = scaled({1'b0, req_write ? st_cfg.write_trail_count : st_cfg.read_trail_count},
                          st_cfg.timing_double);
        // Async selected by enable plus mode bit; extra stage absorbs metastability
        ready_sample = acc_rdy_en ? (cfg[req_zone].ready_async_select ? rdy_s3 : rdy_s2)
                                  : 1'b1;
        do_start = tim_tick & pending & bus_rise & (state == ST_IDLE || state == ST_ALIGN);
        next_state      = state;
        next_cnt        = cnt;
        next_acc_act    = acc_act;
        next_acc_trail  = acc_trail;
        next_acc_write  = acc_write;
        next_acc_rdy_en = acc_rdy_en;
        next_waits      = waits;
        next_cyc        = cyc;
        next_zone_n     = zone_select_n;
        next_rd_n       = read_strobe_n;
        next_wr_n       = write_strobe_n;
        next_dir        = direction_signal;
        next_oe         = data_oe;
        next_addr       = external_address_bus;
        next_rdata      = rdata;
        if (tim_tick) begin
            if (state != ST_IDLE && state != ST_ALIGN) begin
                next_cyc = 8'(cyc + 8'h1);
            end
            case (state)
                ST_IDLE: begin
                    if (pending && !bus_rise) begin
                        next_state = ST_ALIGN;
                    end
                end
                ST_ALIGN: ;
                ST_LEAD: begin
                    if (cnt == 5'h0) begin
                        next_state = ST_ACTIVE;
                        next_cnt   = acc_act;
                        next_rd_n  = acc_write;
                        next_wr_n  = ~acc_write;
                    end else begin
                        next_cnt = 5'(cnt - 5'h1);
                    end
                end
                ST_ACTIVE: begin
                    if (cnt != 5'h0) begin
                        next_cnt = 5'(cnt - 5'h1);
                    end else if (!ready_sample) begin
                        next_waits = 8'(waits + 8'h1);
                    end else begin
                        next_rd_n = 1'b1;
                        next_wr_n = 1'b1;
                        if (!acc_write) begin
                            next_rdata = din_s2;
                        end
                        if (acc_trail != 5'h0) begin
                            next_state = ST_TRAIL;
                            next_cnt   = 5'(acc_trail - 5'h1);
                        end else begin
                            next_state  = ST_IDLE;
                            next_zone_n = '1;
                            next_dir    = 1'b1;
                            next_oe     = 1'b0;
                        end
                    end
                end
                ST_TRAIL: begin
                    if (cnt == 5'h0) begin
                        next_state  = ST_IDLE;
                        next_zone_n = '1;
                        next_dir    = 1'b1;
                        next_oe     = 1'b0;
                    end else begin
                        next_cnt = 5'(cnt - 5'h1);
                    end
                end
                default: next_state = ST_IDLE;
            endcase
            if (do_start) begin
                next_cyc        = 8'h0;
                next_waits      = 8'h0;
                next_acc_act    = st_act;
                next_acc_trail  = st_trail;
                next_acc_write  = req_write;
                next_acc_rdy_en = st_cfg.ready_sample_enable;
                next_addr       = req_addr;
                next_zone_n     = ~(ZONES'(1) << req_zone);
                next_dir        = ~req_write;
                next_oe         = req_write;
                if (st_lead != 5'h0) begin
                    next_state = ST_LEAD;
                    next_cnt   = 5'(st_lead - 5'h1);
                end else begin
                    next_state = ST_ACTIVE;
                    next_cnt   = st_act;
                    next_rd_n  = req_write;
                    next_wr_n  = ~req_write;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state                <= ST_IDLE;
            cnt                  <= 5'h0;
            acc_act              <= 5'h0;
            acc_trail            <= 5'h0;
            acc_write            <= 1'b0;
            acc_rdy_en           <= 1'b0;
            waits                <= 8'h0;
            cyc                  <= 8'h0;
            zone_select_n        <= '1;
            read_strobe_n        <= 1'b1;
            write_strobe_n       <= 1'b1;
            direction_signal     <= 1'b1;
            data_oe              <= 1'b0;
            external_address_bus <= '0;
            rdata                <= '0;
        end else begin
            state                <= next_state;
            cnt                  <= next_cnt;
            acc_act              <= next_acc_act;
            acc_trail            <= next_acc_trail;
            acc_write            <= next_acc_write;
            acc_rdy_en           <= next_acc_rdy_en;
            waits                <= next_waits;
            cyc                  <= next_cyc;
            zone_select_n        <= next_zone_n;
            read_strobe_n        <= next_rd_n;
            write_strobe_n       <= next_wr_n;
            direction_signal     <= next_dir;
            data_oe              <= next_oe;
            external_address_bus <= next_addr;
            rdata                <= next_rdata;
        end
    end

    always_comb data_out = wdata;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_start_tick;
        tim_tick && do_start;
    endsequence

    sequence s_wait_tick;
        tim_tick && state == ST_ACTIVE && cnt == 5'h0 && !ready_sample;
    endsequence

    a_start_on_rise: assert property ($fell(&zone_select_n) |-> $past(bus_rise))
        else $error("access began off a bus clock rising edge");
    a_align_inactive: assert property (state == ST_ALIGN |-> &zone_select_n && read_strobe_n
                                       && write_strobe_n && direction_signal)
        else $error("control active during alignment cycle");
    a_addr_hold: assert property (!$past(do_start) |-> $stable(external_address_bus))
        else $error("address moved outside access start");
    a_no_ready_wait: assert property (!acc_rdy_en |-> waits == 8'h0)
        else $error("wait inserted with ready ignored");
    a_strobe_on_tick: assert property ($changed(read_strobe_n) || $changed(write_strobe_n)
                                       |-> $past(tim_tick))
        else $error("strobe changed off a timing tick");
    a_phase_parity: assert property (bus_half && state inside {ST_LEAD, ST_ACTIVE, ST_TRAIL}
                                     |-> bus_phase != cyc[0])
        else $error("half rate strobe edge parity wrong");
    a_full_rate_rise: assert property (!bus_half && timing_half && ($changed(zone_select_n)
                                       || $changed(read_strobe_n) || $changed(write_strobe_n))
                                       |-> bus_clock_out && !$past(bus_clock_out))
        else $error("full rate strobe change off a bus rising edge");
    a_wait_added: assert property (s_wait_tick |=> state == ST_ACTIVE
                                   && waits == 8'($past(waits) + 8'h1))
        else $error("low ready did not add one wait");
    a_read_select: assert property (!read_strobe_n |-> !(&zone_select_n) && direction_signal)
        else $error("read strobe outside selected read");
    a_start_lines: assert property (s_start_tick |=> !(&zone_select_n) && cyc == 8'h0)
        else $error("access start did not select zone");

endmodule : ebs_external_bus_interface
`default_nettype wire

// *** dv/ebs_mem_model.sv ***
// External memory model on the zone selects, with a stalling ready
`timescale 1ns/10ps
`default_nettype none
module ebs_mem_model (
    input  wire logic        mclk,
    input  wire logic [2:0]  zone_select_n,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [15:0] data_out,
    output logic      [15:0] data_in,
    output logic             external_ready_in,
    output logic      [15:0] wr_seen
);
    int stall = 0;
    always @(posedge mclk) begin
        stall <= (zone_select_n == 3'b111) ? 0 : stall + 1;
        if (!write_strobe_n)
            wr_seen <= data_out;
    end
    // Ready low for six clocks of every access, so the short ready-enabled rows all see waits
    assign external_ready_in = (stall >= 6);
    // Bus not driven outside the strobe: a toggling pattern, never the last word
    assign data_in = !read_strobe_n ? 16'h5a3c : (stall[0] ? 16'hffff : 16'h0000);
endmodule : ebs_mem_model
`default_nettype wire

// *** dv/ebs_external_bus_interface_bench.sv ***
// Self-checking bench: zone timing rows through APB, lengths counted at the pins
`timescale 1ns/10ps
`default_nettype none
module ebs_external_bus_interface_bench;
    import ebs_pkg::*;
    logic        mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, err, bclk, rds_n, wrs_n, dir, oe, rdy, bstart;
    logic [2:0]  zs_n;
    logic [18:0] xa;
    logic [15:0] din, dout, wseen;
    int          n_errors = 0, checked = 0, nsel, nstb, ndir, m, td, ws, cfg, es, et;
    // zone, lead, active, trail, double, ready enable, async, clkctl, write
    int          rows [6][9] = '{'{0,1,0,0,0,0,0,0,0}, '{1,1,1,0,1,1,1,0,1}, '{2,2,1,0,0,1,0,2,0},
                                 '{0,3,7,3,1,0,0,3,1}, '{1,0,0,0,0,0,0,1,0}, '{2,1,2,0,0,1,1,2,1}};
    ebs_external_bus_interface u_ebs_external_bus_interface (.mclk(mclk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_clock_out(bclk), .external_address_bus(xa),
        .zone_select_n(zs_n), .read_strobe_n(rds_n), .write_strobe_n(wrs_n), .direction_signal(dir),
        .data_in(din), .data_out(dout), .data_oe(oe), .external_ready_in(rdy));
    ebs_mem_model u_ebs_mem_model (.mclk(mclk), .zone_select_n(zs_n), .read_strobe_n(rds_n),
        .write_strobe_n(wrs_n), .data_out(dout), .data_in(din), .external_ready_in(rdy), .wr_seen(wseen));
    always #12.5 mclk = ~mclk;
    // Counted at the falling edge, where the pins have settled
    always @(negedge mclk) begin
        if (zs_n != 3'b111 && nsel == 0) bstart = bclk;
        if (zs_n != 3'b111) nsel++;
        if (!rds_n || !wrs_n) nstb++;
        if (!dir) ndir++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Request held until the rising edge that sees pready; one idle edge keeps calls apart
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        n_errors++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        chk("idle controls", {zs_n, rds_n, wrs_n, dir}, 6'h3f);
        apb(1'b0, OFF_ZONE0, 32'h0, r);
        chk("zone reset", r, 32'(ZONE_CFG_RESET));
        apb(1'b0, 8'h22, 32'h0, r);
        chk("unmapped error", err, 1'b1);
        foreach (rows[i]) begin
            m = rows[i][4] ? 2 : 1;
            td = rows[i][7][0] ? 2 : 1;
            cfg = (rows[i][3] << 5) | (rows[i][2] << 2) | rows[i][1];
            apb(1'b1, 8'(4 * rows[i][0]), 32'((rows[i][6] << 16) | (rows[i][5] << 15) | (rows[i][4] << 14)
                | (cfg << 7) | cfg), r);
            apb(1'b1, OFF_CLKCTL, 32'(rows[i][7]), r);
            apb(1'b1, OFF_WDATA, 32'h0000c3a0 + i, r);
            nsel = 0;
            nstb = 0;
            ndir = 0;
            apb(1'b1, OFF_REQ, 32'((rows[i][8] << 21) | (rows[i][0] << 19) | (32'h1234 + i * 32'h1111)), r);
            r = 32'h1;
            for (int k = 0; k < 100 && r[0]; k++) apb(1'b0, OFF_STATUS, 32'h0, r);
            ws = r[15:8];
            et = td * (rows[i][2] * m + 1 + ws);
            es = td * ((rows[i][1] + rows[i][3]) * m) + et;
            chk("busy", r[0], 1'b0);
            chk("select length", nsel, es);
            chk("strobe length", nstb, et);
            chk("direction length", ndir, rows[i][8] ? es : 0);
            chk("wait count", ws != 0, rows[i][5]);
            chk("start edge", bstart, 1'b1);
            chk("address hold", xa, 19'(32'h1234 + i * 32'h1111));
            if (rows[i][8])
                chk("write word", wseen, 16'hc3a0 + 16'(i));
            else if (et > 2) begin
                apb(1'b0, OFF_RDATA, 32'h0, r);
                chk("read word", r[15:0], 16'h5a3c);
            end
        end
        // Reset in mid-access: lines drop to idle at once, zone settings return to defaults
        apb(1'b1, OFF_REQ, 32'h1, r);
        repeat (8) @(posedge mclk);
        chk("select running", zs_n[0], 1'b0);
        rstn <= 1'b0;
        @(posedge mclk);
        chk("reset lines", {zs_n, rds_n, wrs_n, dir, oe}, 7'h7e);
        chk("reset address", xa, 19'h0);
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        apb(1'b0, OFF_ZONE2, 32'h0, r);
        chk("zone after reset", r, 32'(ZONE_CFG_RESET));
        test_done();
    end
endmodule : ebs_external_bus_interface_bench
`default_nettype wire
